// >>> verilog/asr_pkg.sv
// How it works
// - one holding latch plus 31 scratch registers serve control-store-tied tasks.
// - large option gives 8 banks of 31 scratch registers each.
// - holding latch loads ALU output only when load-accumulator bit is set.
// - scratch writes come from latch; reads drive bus; picked by select field.
// - bus-origin field decode decides scratch write or read.
// - latch and scratch registers act only in control-store-tied tasks.
// - latch to scratch register path carries data unshifted.
// - bus value is undefined during a scratch write.
// - selection uses select field directly; accumulator swaps do not alter it.
// - reading select 0 returns the holding latch value.
// - large option keeps a 3-bit bank per task, used for every access.
// - bank-pick functions load running task bank from bus bits 12 to 14.
// - bank pick is function code 15 in emulator, 13 in other tied tasks.
// - without large option code 13 loads reset-bank-mode register everywhere.
// - bootstrap reset clears every task bank number to zero.
// - control-store read or write stalls the system clock one cycle.
// - rom reads address only by next-address path, next word at x mod 1024.
// - control-store rom reads reach only the first rom bank.
// - store write uses latch for high half, next ALU output for low half.
package asr_pkg;
  localparam int          DATA_W     = 16;
  localparam int          NUM_TASKS  = 16;
  localparam int          NUM_BANKS  = 8;
  localparam int          BANK_W     = 3;
  localparam int          SEL_W      = 5;
  localparam int          BANK_LSB   = 12;
  localparam logic [3:0]  EMU_TASK   = 4'h0;
  localparam logic [3:0]  F1_RDSTORE = 4'hA;  // 12B
  localparam logic [3:0]  F1_WRSTORE = 4'hB;  // 13B would be 11; 12B=10, 13B=11
  localparam logic [3:0]  F1_TASKBNK = 4'hB;  // 13B
  localparam logic [3:0]  F1_EMUBNK  = 4'hD;  // 15B
  localparam logic [2:0]  BS_SREAD   = 3'h3;
  localparam logic [2:0]  BS_SWRITE  = 3'h4;
  localparam logic [15:0] BANKMAP_RST = 16'hFFFF;
  localparam logic [2:0]  BANK_RST   = 3'h0;
  typedef enum logic [1:0] {ASR_RUN, ASR_STALL} asr_stall_e;
endpackage

// >>> verilog/asr_bank_store.sv
`timescale 1ns/1ps
`default_nettype none
// one bank of scratch words held in flip-flops; word 0 is never stored
module asr_bank_store
  import asr_pkg::*;
#(
  parameter int WORDS = 32
)(
  input  wire logic              sys_clk,
  input  wire logic              wrEn,
  input  wire logic [SEL_W-1:0]  wrIdx,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [SEL_W-1:0]  rdIdx,
  output logic      [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem_q [WORDS];
  logic [DATA_W-1:0] mem_d [WORDS];

  // write port; contents survive reset like the real scratch memory
  always_comb
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (wrEn && wrIdx != '0)
    begin
      mem_d[wrIdx] = wrData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    mem_q <= mem_d;
  end

  assign rdData = mem_q[rdIdx];
endmodule
`default_nettype wire

// >>> verilog/asr_scratch_bank.sv
`timescale 1ns/1ps
`default_nettype none
module asr_scratch_bank
  import asr_pkg::*;
#(
  parameter bit LARGE_OPT = 1'b1,
  parameter int BANKS     = NUM_BANKS
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           taskNum,
  input  wire logic [NUM_TASKS-1:0] taskTied,
  input  wire logic [SEL_W-1:0]     regPickField,
  input  wire logic [2:0]           busOriginField,
  input  wire logic [3:0]           functionOneField,
  input  wire logic                 loadAccBit,
  input  wire logic                 emuAccInSwap,
  input  wire logic                 emuAccOutSwap,
  input  wire logic [DATA_W-1:0]    aluOut,
  input  wire logic [DATA_W-1:0]    procBusIn,
  output logic      [DATA_W-1:0]    busData,
  output logic                      busDrive,
  output logic      [DATA_W-1:0]    holdLatch,
  output logic      [NUM_TASKS-1:0] bootBankMap,
  output logic                      clkStall,
  output logic                      storeWrStrobe,
  output logic      [2*DATA_W-1:0]  storeWrWord,
  output logic                      storeRdStrobe,
  output logic                      storeRdRomOnly
);
  // accumulator swap inputs are accepted but never steer selection
  logic unusedSwap;
  assign unusedSwap = emuAccInSwap ^ emuAccOutSwap;

  logic tied;
  logic sRead;
  logic sWrite;
  logic isEmu;
  logic bankPick;
  logic mapLoad;
  logic [BANK_W-1:0] curBank;

  // decode of the current microinstruction
  always_comb
  begin
    tied     = taskTied[taskNum];
    isEmu    = (taskNum == EMU_TASK);
    sRead    = tied && (busOriginField == BS_SREAD);
    sWrite   = tied && (busOriginField == BS_SWRITE);
    bankPick = LARGE_OPT && tied &&
               ((isEmu && functionOneField == F1_EMUBNK) ||
                (!isEmu && functionOneField == F1_TASKBNK));
    mapLoad  = tied && functionOneField == F1_TASKBNK &&
               (!LARGE_OPT || isEmu);
  end

  // per-task bank numbers
  logic [BANK_W-1:0] bankNum_q [NUM_TASKS];
  logic [BANK_W-1:0] bankNum_d [NUM_TASKS];

  always_comb
  begin
    for (int t = 0; t < NUM_TASKS; t++)
    begin
      bankNum_d[t] = bankNum_q[t];
    end
    // the function only ever targets the running task
    if (bankPick)
    begin
      bankNum_d[taskNum] = procBusIn[BANK_LSB +: BANK_W];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int t = 0; t < NUM_TASKS; t++)
      begin
        bankNum_q[t] <= BANK_RST;
      end
    end
    else
    begin
      bankNum_q <= bankNum_d;
    end
  end

  assign curBank = LARGE_OPT ? bankNum_q[taskNum] : BANK_RST;

  // holding latch, reset-bank-mode map and stall sequencer
  logic [DATA_W-1:0]    hold_q, hold_d;
  logic [NUM_TASKS-1:0] map_q, map_d;
  asr_stall_e           st_q, st_d;
  logic                 stall_q, stall_d;
  logic                 wrPend_q, wrPend_d;
  logic [DATA_W-1:0]    wrHigh_q, wrHigh_d;
  logic                 wrStb_q, wrStb_d;
  logic [2*DATA_W-1:0]  wrWord_q, wrWord_d;
  logic                 rdStb_q, rdStb_d;
  logic                 isStore;

  always_comb
  begin
    isStore  = tied && (functionOneField == F1_RDSTORE ||
                        functionOneField == F1_WRSTORE);
    hold_d   = hold_q;
    map_d    = map_q;
    st_d     = st_q;
    stall_d  = 1'b0;
    wrPend_d = wrPend_q;
    wrHigh_d = wrHigh_q;
    wrStb_d  = 1'b0;
    wrWord_d = wrWord_q;
    rdStb_d  = 1'b0;
    if (tied && loadAccBit)
    begin
      hold_d = aluOut;
    end
    if (mapLoad)
    begin
      map_d = procBusIn;
    end
    case (st_q)
      ASR_RUN:
      begin
        if (isStore)
        begin
          st_d    = ASR_STALL;
          stall_d = 1'b1;
          rdStb_d = (functionOneField == F1_RDSTORE);
          wrPend_d = (functionOneField == F1_WRSTORE);
        end
      end
      ASR_STALL:
      begin
        // latch after the write cycle forms the high half
        st_d = ASR_RUN;
        if (wrPend_q)
        begin
          wrHigh_d = hold_q;
        end
      end
      default:
      begin
        st_d = ASR_RUN;
      end
    endcase
    // low half is the ALU output of the following microinstruction
    if (st_q == ASR_STALL && wrPend_q)
    begin
      wrStb_d  = 1'b1;
      wrWord_d = {hold_q, aluOut};
      wrPend_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q   <= '0;
      map_q    <= BANKMAP_RST;
      st_q     <= ASR_RUN;
      stall_q  <= 1'b0;
      wrPend_q <= 1'b0;
      wrHigh_q <= '0;
      wrStb_q  <= 1'b0;
      wrWord_q <= '0;
      rdStb_q  <= 1'b0;
    end
    else
    begin
      hold_q   <= hold_d;
      map_q    <= map_d;
      st_q     <= st_d;
      stall_q  <= stall_d;
      wrPend_q <= wrPend_d;
      wrHigh_q <= wrHigh_d;
      wrStb_q  <= wrStb_d;
      wrWord_q <= wrWord_d;
      rdStb_q  <= rdStb_d;
    end
  end

  // scratch banks; write data is the latch as is, no shifter
  logic [DATA_W-1:0] bankRd [BANKS];
  genvar g;
  for (g = 0; g < BANKS; g++)
  begin : gBank
    asr_bank_store #(.WORDS(32)) uStore (
      .sys_clk (sys_clk),
      .wrEn    (sWrite && curBank == BANK_W'(g)),
      .wrIdx   (regPickField),
      .wrData  (hold_q),
      .rdIdx   (regPickField),
      .rdData  (bankRd[g])
    );
  end

  // bus drive registered; select 0 returns the latch, word 0 is never a register
  logic [DATA_W-1:0] bus_q, bus_d;
  logic              drv_q, drv_d;

  always_comb
  begin
    bus_d = bus_q;                          // write cycles leave bus undefined
    drv_d = sRead;
    if (sRead)
    begin
      bus_d = (regPickField == '0) ? hold_q : bankRd[curBank];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_q <= '0;
      drv_q <= 1'b0;
    end
    else
    begin
      bus_q <= bus_d;
      drv_q <= drv_d;
    end
  end

  assign busData        = bus_q;
  assign busDrive       = drv_q;
  assign holdLatch      = hold_q;
  assign bootBankMap    = map_q;
  assign clkStall       = stall_q;
  assign storeWrStrobe  = wrStb_q;
  assign storeWrWord    = wrWord_q;
  assign storeRdStrobe  = rdStb_q;
  assign storeRdRomOnly = rdStb_q;  // only first rom bank is ever readable
endmodule
`default_nettype wire

// >>> tb/asr_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asr_props
  import asr_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic [3:0]           taskNum,
  input wire logic [NUM_TASKS-1:0] taskTied,
  input wire logic [SEL_W-1:0]     regPickField,
  input wire logic [2:0]           busOriginField,
  input wire logic [3:0]           functionOneField,
  input wire logic                 loadAccBit,
  input wire logic [DATA_W-1:0]    aluOut,
  input wire logic [DATA_W-1:0]    busData,
  input wire logic                 busDrive,
  input wire logic [DATA_W-1:0]    holdLatch,
  input wire logic                 clkStall,
  input wire logic                 storeRdStrobe,
  input wire logic                 storeRdRomOnly,
  input wire logic                 storeWrStrobe,
  input wire logic [2*DATA_W-1:0]  storeWrWord
);
  // a request counts only while a control-store-tied task runs
  wire logic act = taskTied[taskNum];
  wire logic rdReq = act && (busOriginField == BS_SREAD);
  wire logic stReq = act && (functionOneField == F1_RDSTORE) && !clkStall;
  wire logic swReq = act && (functionOneField == F1_WRSTORE) && !clkStall;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_LATCH_LOAD: assert property (act && loadAccBit |=> holdLatch == $past(aluOut))
    else $error("latch did not take the alu value");
  AST_LATCH_HOLD: assert property (!(act && loadAccBit) |=> $stable(holdLatch))
    else $error("latch changed without a load");
  AST_READ_DRIVE: assert property (rdReq |=> busDrive)
    else $error("scratch read did not drive the bus");
  AST_NO_DRIVE: assert property (!rdReq |=> !busDrive)
    else $error("bus driven without a scratch read");
  AST_SEL0: assert property (rdReq && regPickField == 0 |=> busData == $past(holdLatch))
    else $error("select zero did not return the latch");
  AST_BUS_HOLD: assert property (!rdReq |=> $stable(busData))
    else $error("read data moved without a read");
  AST_STALL: assert property (stReq |=> clkStall ##1 !clkStall)
    else $error("store access stall is not one cycle");
  AST_RD_STROBE: assert property (stReq |=> storeRdStrobe && storeRdRomOnly)
    else $error("store read not issued to the first rom bank");
  // high half is the latch after the write cycle, low half the next alu value
  AST_WR_WORD: assert property (swReq |=> ##1 storeWrStrobe && storeWrWord == {$past(holdLatch), $past(aluOut)})
    else $error("store write word not formed from latch and alu");
endmodule
bind asr_scratch_bank asr_props u_props (.sys_clk, .rst_n, .taskNum, .taskTied,
  .regPickField, .busOriginField, .functionOneField, .loadAccBit, .aluOut, .busData,
  .busDrive, .holdLatch, .clkStall, .storeRdStrobe, .storeRdRomOnly, .storeWrStrobe,
  .storeWrWord);
`default_nettype wire

// >>> tb/asr_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_seq_model
  import asr_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [5:0]        regNum,
  input  wire logic              bankPut,
  input  wire logic [BANK_W-1:0] bankVal,
  input  wire logic [DATA_W-1:0] busData,
  input  wire logic              busDrive,
  output logic      [SEL_W-1:0]  regPickField,
  output logic      [DATA_W-1:0] procBusIn
);
  logic [DATA_W-1:0] noise = 16'h1D3B;
  // microcode numbers slots 40B..77B; the select field keeps the low five bits
  assign regPickField = regNum[SEL_W-1:0];
  // a released bus shows a moving pattern, so stale data never passes
  always @(posedge sys_clk)
    noise <= {noise[14:0], noise[15] ^ noise[3]};
  // bank number rides on bits 14:12 during a bank pick
  assign procBusIn = bankPut ? {1'b0, bankVal, 12'h000} : (busDrive ? busData : noise);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
  begin \
    comparisons++; \
    if ((s) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected %s: expected %h seen %h", n, e, s); \
    end \
  end
module tb_top
  import asr_pkg::*;
;
  logic        sys_clk = 1'b0, rst_n = 1'b0, ld = 1'b0, bp = 1'b0, swp = 1'b0;
  logic [3:0]  tk = 4'h0, f1 = 4'h0, t;
  logic [2:0]  bs = 3'h0, bv = 3'h0;
  logic [5:0]  rn = 6'h20;
  logic [15:0] alu = 16'h0000, tied = 16'hFFDF, v, busIn, busData, hl, bootBankMap, lat;
  logic [4:0]  sel, s;
  logic [31:0] r, wrW;
  logic        busDrive, clkStall, wrS, rdS, rdR;
  logic [15:0] sm [8][32];
  bit          ok [8][32];
  logic [2:0]  bk [16];
  int          n_fail = 0, comparisons = 0, seed = 54;
  asr_scratch_bank uut (.sys_clk, .rst_n, .taskNum(tk), .taskTied(tied), .regPickField(sel),
    .busOriginField(bs), .functionOneField(f1), .loadAccBit(ld), .emuAccInSwap(swp),
    .emuAccOutSwap(~swp), .aluOut(alu), .procBusIn(busIn), .busData, .busDrive,
    .holdLatch(hl), .bootBankMap, .clkStall, .storeWrStrobe(wrS), .storeWrWord(wrW),
    .storeRdStrobe(rdS), .storeRdRomOnly(rdR));
  asr_seq_model sq (.sys_clk, .regNum(rn), .bankPut(bp), .bankVal(bv), .busData,
    .busDrive, .regPickField(sel), .procBusIn(busIn));
  // free-running clock, 4 ns period
  initial forever #2 sys_clk = ~sys_clk;
  // one microinstruction; the reference model follows the rising edge
  task automatic step(input logic [3:0] tt, input logic [4:0] ss, input logic [2:0] b,
                      input logic [3:0] f, input logic l, input logic [15:0] a);
    @(negedge sys_clk);
    r = $random(seed);
    tk = tt;
    rn = {1'b1, ss};
    bs = b;
    f1 = f;
    ld = l;
    alu = a;
    swp = r[0];
    bv = r[3:1];
    bp = (tt == EMU_TASK) ? (f == F1_EMUBNK) : (f == F1_TASKBNK);
    @(posedge sys_clk);
    if (tied[tt])
    begin
      if (b == BS_SWRITE && ss != 0)
      begin
        sm[bk[tt]][ss] = lat;
        ok[bk[tt]][ss] = 1'b1;
      end
      if (bp)
        bk[tt] = bv;
      if (l)
        lat = a;
    end
  endtask
  // scratch read, checked the cycle after it is taken
  task automatic rd(input logic [3:0] tt, input logic [4:0] ss);
    logic [15:0] e;
    e = (ss == 0) ? lat : sm[bk[tt]][ss];
    step(tt, ss, BS_SREAD, 4'h0, 1'b0, 16'h0000);
    #1 `CHK("busData", e, busData)
  endtask
  // reset also clears the bench's latch and bank numbers
  task automatic reset();
    rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    lat = 16'h0000;
    foreach (bk[i]) bk[i] = 3'h0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    reset();
    `CHK("holdLatch", 16'h0000, hl)
    `CHK("bootBankMap", BANKMAP_RST, bootBankMap)
    repeat (40)
    begin
      r = $random(seed);
      v = r[15:0];
      s = r[20:16] | 5'h01;
      t = r[21] ? 4'h0 : 4'h3;
      step(t, 5'h00, 3'h0, t == 4'h0 ? F1_EMUBNK : F1_TASKBNK, 1'b1, v);
      step(t, s, BS_SWRITE, 4'h0, 1'b0, ~v);
      rd(t, s);
      if (ok[bk[t]][5'h1F])
        rd(t, 5'h1F);
    end
    $display("test banks done");
    step(4'h0, 5'h00, 3'h0, 4'h0, 1'b1, 16'hA5C3);
    step(4'h0, 5'h00, BS_SWRITE, 4'h0, 1'b0, 16'h0000);
    rd(4'h0, 5'h00);
    step(4'h5, 5'h02, BS_SWRITE, 4'h0, 1'b1, 16'h1111);
    step(4'h5, 5'h02, BS_SREAD, 4'h0, 1'b0, 16'h0000);
    #1 `CHK("busDrive", 1'b0, busDrive)
    rd(4'h0, 5'h00);
    // map load takes the word still driven by the read just before
    step(4'h0, 5'h00, 3'h0, F1_WRSTORE, 1'b1, 16'hB7E1);
    #1 `CHK("bootBankMap", 16'hA5C3, bootBankMap)
    `CHK("clkStall", 1'b1, clkStall)
    step(4'h0, 5'h00, 3'h0, 4'h0, 1'b0, 16'h3C96);
    #1 `CHK("storeWrStrobe", 1'b1, wrS)
    `CHK("storeWrWord", 32'hB7E1_3C96, wrW)
    $display("test latch done");
    step(4'h0, 5'h00, 3'h0, F1_RDSTORE, 1'b0, 16'h0000);
    #1 `CHK("clkStall", 1'b1, clkStall)
    `CHK("storeRdRomOnly", 1'b1, rdR)
    step(4'h0, 5'h00, 3'h0, 4'h0, 1'b0, 16'h0000);
    #1 `CHK("clkStall", 1'b0, clkStall)
    $display("test stall done");
    reset();
    `CHK("bootBankMap", BANKMAP_RST, bootBankMap)
    for (int i = 1; i < 32; i++)
      if (ok[0][i])
        rd(4'h3, 5'(i));
    $display("test reset done");
    wrap_up();
  end
  // the run needs well under 1000 cycles; 5000 means a hang
  initial
  begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
